// >>> sws_consts.svh
// Purpose: constants for the status word store unit
// Assumes: 16-bit data, 16-bit addresses
// Notes:   direct page forced to zero on status stores
`ifndef SWS_CONSTS_SVH
`define SWS_CONSTS_SVH

`define SWS_OPC_HI       7'h3C
`define SWS_OPC_ZERO     1'b0
`define SWS_OPC_ONE      1'b1
`define SWS_IND_BIT      7
`define SWS_OFS_W        7
`define SWS_PAGE_ZERO    9'h000
`define SWS_ST0_ARP_LSB  13
`define SWS_ST0_OV_BIT   12
`define SWS_ST0_OVM_BIT  11
`define SWS_ST0_ONE_BIT  10
`define SWS_ST0_GLOBAL_IRQ_MASK_BIT 9
`define SWS_ST1_ARB_LSB  13
`define SWS_ST1_CNF_BIT  12
`define SWS_ST1_TC_BIT   11
`define SWS_ST1_SXM_BIT  10
`define SWS_ST1_C_BIT    9
`define SWS_ST1_ONE_BIT  8
`define SWS_ST1_RAM_CONFIG_HIGH_BIT 7
`define SWS_ST1_HM_BIT   6
`define SWS_ST1_FSM_BIT  5
`define SWS_ST1_XF_BIT   4
`define SWS_ST1_FO_BIT   3
`define SWS_ST1_TXM_BIT  2

`endif

// >>> sws_pkg.sv
// Purpose: types for the status word store unit
// Assumes: nothing
// Notes:   one-hot state codes
package sws_pkg;
    typedef enum logic [1:0] {
        SWS_IDLE  = 2'b01,
        SWS_WRITE = 2'b10
    } sws_state_t;
endpackage

// >>> sws_st0_pack.sv
// Purpose: builds the status word zero memory image
// Assumes: fields already registered by the core
// Notes:   combinational
`timescale 1ns/1ps
`include "sws_consts.svh"
module sws_st0_pack (
    // Fields
    input  wire logic [2:0]  arp_i,
    input  wire logic        ov_i,
    input  wire logic        ovm_i,
    input  wire logic        global_irq_mask_i,
    input  wire logic [8:0]  dp_i,
    // Image
    output logic      [15:0] word_o
);
    always_comb begin
        word_o = 16'h0000;
        word_o[`SWS_ST0_ARP_LSB +: 3] = arp_i;
        word_o[`SWS_ST0_OV_BIT]       = ov_i;
        word_o[`SWS_ST0_OVM_BIT]      = ovm_i;
        word_o[`SWS_ST0_ONE_BIT]      = 1'b1;
        word_o[`SWS_ST0_GLOBAL_IRQ_MASK_BIT]     = global_irq_mask_i;
        word_o[8:0]                   = dp_i;
    end
endmodule // sws_st0_pack

// >>> sws_st1_pack.sv
// Purpose: builds the status word one memory image
// Assumes: fields already registered by the core
// Notes:   TWO_BIT_CNF selects the two-bit RAM configuration variant
`timescale 1ns/1ps
`include "sws_consts.svh"
module sws_st1_pack #(
    parameter bit TWO_BIT_CNF = 1'b0
) (
    // Fields
    input  wire logic [2:0]  arb_i,
    input  wire logic [1:0]  cnf_i,
    input  wire logic        tc_i,
    input  wire logic        sxm_i,
    input  wire logic        c_i,
    input  wire logic        hm_i,
    input  wire logic        fsm_i,
    input  wire logic        xf_i,
    input  wire logic        fo_i,
    input  wire logic        txm_i,
    input  wire logic [1:0]  pm_i,
    // Image
    output logic      [15:0] word_o
);
    always_comb begin
        word_o = 16'h0000;
        word_o[`SWS_ST1_ARB_LSB +: 3] = arb_i;
        word_o[`SWS_ST1_CNF_BIT]      = cnf_i[0];
        word_o[`SWS_ST1_TC_BIT]       = tc_i;
        word_o[`SWS_ST1_SXM_BIT]      = sxm_i;
        word_o[`SWS_ST1_C_BIT]        = c_i;
        word_o[`SWS_ST1_ONE_BIT]      = 1'b1;
        word_o[`SWS_ST1_RAM_CONFIG_HIGH_BIT]     = TWO_BIT_CNF ? cnf_i[1] : 1'b1;
        word_o[`SWS_ST1_HM_BIT]       = hm_i;
        word_o[`SWS_ST1_FSM_BIT]      = fsm_i;
        word_o[`SWS_ST1_XF_BIT]       = xf_i;
        word_o[`SWS_ST1_FO_BIT]       = fo_i;
        word_o[`SWS_ST1_TXM_BIT]      = txm_i;
        word_o[1:0]                   = pm_i;
    end
endmodule // sws_st1_pack

// >>> sws_store_unit.sv
// Purpose: executes the two status-store instructions
// Assumes: one instruction offered per valid pulse, status fields stable
// Notes:   the page pointer is only read, never written here
`timescale 1ns/1ps
`include "sws_consts.svh"
module sws_store_unit #(
    parameter bit TWO_BIT_CNF = 1'b0
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // Instruction
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_i,
    // Address source
    input  wire logic [15:0] aux_reg_i,
    // Status word zero fields
    input  wire logic [2:0]  arp_i,
    input  wire logic        ov_i,
    input  wire logic        ovm_i,
    input  wire logic        global_irq_mask_i,
    input  wire logic [8:0]  dp_i,
    // Status word one fields
    input  wire logic [2:0]  arb_i,
    input  wire logic [1:0]  cnf_i,
    input  wire logic        tc_i,
    input  wire logic        sxm_i,
    input  wire logic        c_i,
    input  wire logic        hm_i,
    input  wire logic        fsm_i,
    input  wire logic        xf_i,
    input  wire logic        fo_i,
    input  wire logic        txm_i,
    input  wire logic [1:0]  pm_i,
    // Data memory write
    output logic             mem_we_o,
    output logic      [15:0] mem_addr_o,
    output logic      [15:0] mem_data_o,
    // Status
    output logic             busy_o
);
    // ****************************************
    // Decode
    // ****************************************
    logic        is_store;
    logic        sel_one;
    logic        indirect;
    logic [15:0] st0_word;
    logic [15:0] st1_word;
    logic [15:0] addr_calc;

    logic        opc_match;
    logic        sel_zero;

    // Opcode field and word select
    always_comb begin
        opc_match = instr_i[15:9] == `SWS_OPC_HI;
        sel_zero  = instr_i[8] == `SWS_OPC_ZERO;
    end

    always_comb begin
        is_store = instr_valid_i && opc_match;
        sel_one  = instr_i[8] == `SWS_OPC_ONE;
        indirect = instr_i[`SWS_IND_BIT];
        if (indirect) begin
            addr_calc = aux_reg_i;
        end else begin
            addr_calc = {`SWS_PAGE_ZERO, instr_i[`SWS_OFS_W-1:0]};
        end
    end

    sws_st0_pack u_st0 (
        .arp_i  (arp_i),
        .ov_i   (ov_i),
        .ovm_i  (ovm_i),
        .global_irq_mask_i (global_irq_mask_i),
        .dp_i   (dp_i),
        .word_o (st0_word)
    );

    sws_st1_pack #(.TWO_BIT_CNF(TWO_BIT_CNF)) u_st1 (
        .arb_i  (arb_i),
        .cnf_i  (cnf_i),
        .tc_i   (tc_i),
        .sxm_i  (sxm_i),
        .c_i    (c_i),
        .hm_i   (hm_i),
        .fsm_i  (fsm_i),
        .xf_i   (xf_i),
        .fo_i   (fo_i),
        .txm_i  (txm_i),
        .pm_i   (pm_i),
        .word_o (st1_word)
    );

    // ****************************************
    // Write sequencing
    // ****************************************
    sws_pkg::sws_state_t state_reg;
    sws_pkg::sws_state_t state_next;
    logic                we_reg;
    logic                we_next;
    logic [15:0]         addr_reg;
    logic [15:0]         addr_next;
    logic [15:0]         data_reg;
    logic [15:0]         data_next;
    logic                busy_reg;
    logic                busy_next;

    always_comb begin
        state_next = state_reg;
        we_next    = 1'b0;
        busy_next  = 1'b0;
        addr_next  = addr_reg;
        data_next  = data_reg;
        case (state_reg)
            sws_pkg::SWS_IDLE: begin
                if (is_store) begin
                    we_next    = 1'b1;
                    busy_next  = 1'b1;
                    addr_next  = addr_calc;
                    data_next  = sel_one ? st1_word : st0_word;
                    state_next = sws_pkg::SWS_WRITE;
                end
            end
            sws_pkg::SWS_WRITE: begin
                state_next = sws_pkg::SWS_IDLE;
            end
            default: begin
                state_next = sws_pkg::SWS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_reg <= sws_pkg::SWS_IDLE;
            we_reg    <= 1'b0;
            busy_reg  <= 1'b0;
            addr_reg  <= 16'h0000;
            data_reg  <= 16'h0000;
        end else begin
            state_reg <= state_next;
            we_reg    <= we_next;
            busy_reg  <= busy_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
        end
    end

    // Page pointer is an input only, so it cannot be altered
    assign mem_we_o   = we_reg;
    assign mem_addr_o = addr_reg;
    assign mem_data_o = data_reg;
    assign busy_o     = busy_reg;

    // ****************************************
    // Checks
    // ****************************************
    store_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(state_reg == sws_pkg::SWS_WRITE) |-> mem_we_o)
        else $error("store did not raise write enable");
    st0_data_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && !sel_one)
        |=> mem_data_o == $past(st0_word))
        else $error("word zero image not stored");
    st1_data_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && sel_one)
        |=> mem_data_o == $past(st1_word))
        else $error("word one image not stored");
    direct_page_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && !indirect)
        |=> mem_addr_o[15:7] == 9'h000)
        else $error("direct store not on page zero");
    direct_ofs_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && !indirect)
        |=> mem_addr_o[6:0] == $past(instr_i[6:0]))
        else $error("direct offset wrong");
    indirect_addr_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && indirect)
        |=> mem_addr_o == $past(aux_reg_i))
        else $error("indirect address wrong");
    st0_layout_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st0_word == {arp_i, ov_i, ovm_i, 1'b1, global_irq_mask_i, dp_i})
        else $error("word zero layout wrong");
    st1_layout_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st1_word[15:8] == {arb_i, cnf_i[0], tc_i, sxm_i, c_i, 1'b1}
        && st1_word[6:0] == {hm_i, fsm_i, xf_i, fo_i, txm_i, pm_i})
        else $error("word one layout wrong");
    cnf_high_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st1_word[7] == (TWO_BIT_CNF ? cnf_i[1] : 1'b1))
        else $error("bit 7 of word one wrong");
    single_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        mem_we_o |=> !mem_we_o)
        else $error("write held longer than one cycle");

    reset_quiet_a: assert property (@(posedge sys_clk_i)
        !resetn_i |=> !mem_we_o && !busy_o)
        else $error("outputs active after reset");
    take_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store) |=> mem_we_o)
        else $error("taken store gave no strobe");
    no_spurious_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !(state_reg == sws_pkg::SWS_IDLE && is_store) |=> !mem_we_o)
        else $error("strobe without a taken store");
    refuse_busy_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (busy_o && instr_valid_i) |=> !mem_we_o)
        else $error("store taken while busy");
    other_opc_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (instr_valid_i && !opc_match) |=> !mem_we_o)
        else $error("foreign opcode stored");
    busy_track_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        busy_o == mem_we_o)
        else $error("busy and strobe disagree");
    busy_single_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        busy_o |=> !busy_o)
        else $error("busy held longer than one cycle");
    hold_addr_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !(state_reg == sws_pkg::SWS_IDLE && is_store)
        |=> $stable(mem_addr_o) && $stable(mem_data_o))
        else $error("address or data moved without a store");
    state_onehot_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $onehot(state_reg))
        else $error("state not one-hot");
    st0_page_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && sel_zero)
        |=> mem_data_o[8:0] == $past(dp_i))
        else $error("stored page pointer differs from its register");
    st0_one_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st0_word[`SWS_ST0_ONE_BIT] == 1'b1)
        else $error("word zero fixed one missing");
    st1_one_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st1_word[`SWS_ST1_ONE_BIT] == 1'b1)
        else $error("word one fixed one missing");
    st1_cnf_low_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st1_word[`SWS_ST1_CNF_BIT] == cnf_i[0])
        else $error("bit 12 of word one wrong");
    ind_full_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && indirect && aux_reg_i[15:7] != 9'h000)
        |=> mem_addr_o[15:7] != 9'h000)
        else $error("indirect address was page forced");

    direct_cov_c: cover property (@(posedge sys_clk_i) mem_we_o && mem_addr_o[15:7] == 9'h000);
    refuse_cov_c: cover property (@(posedge sys_clk_i) busy_o && instr_valid_i && opc_match);
    st0_cov_c: cover property (@(posedge sys_clk_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && sel_zero) ##1 mem_we_o);
    st1_cov_c: cover property (@(posedge sys_clk_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && sel_one) ##1 mem_we_o);
    ind_cov_c: cover property (@(posedge sys_clk_i)
        (state_reg == sws_pkg::SWS_IDLE && is_store && indirect) ##1 mem_we_o);
endmodule // sws_store_unit

// >>> sws_mem_model.sv
// Purpose: data memory model behind the store unit
// Assumes: one word written per strobe
// Notes:   counts writes so dropped stores show up
`timescale 1ns/1ps
module sws_mem_model (
    // Clock and write port
    input  wire logic        sys_clk_i,
    input  wire logic        we_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] data_i
);
    // ****************
    // Storage
    // ****************
    logic [15:0] mem [0:65535];
    int          wr_count = 0;

    always @(posedge sys_clk_i) begin
        if (we_i === 1'b1) begin
            mem[addr_i] <= data_i;
            wr_count    <= wr_count + 1;
        end
    end
endmodule // sws_mem_model

// >>> tb.sv
// Purpose: self-checking bench for the status word store unit
// Assumes: store answered one cycle after it is taken
// Notes:   second unit instance covers the two-bit RAM variant
`timescale 1ns/1ps
module tb;
    // ****************
    // Signals
    // ****************
    logic        sys_clk_i = 1'b0, resetn_i = 1'b0, instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000, aux_reg_i = 16'h0000;
    logic [2:0]  arp_i = 3'h0, arb_i = 3'h0;
    logic [8:0]  dp_i = 9'h000;
    logic [1:0]  cnf_i = 2'h0, pm_i = 2'h0;
    logic        ov_i = 1'b0, ovm_i = 1'b0, global_irq_mask_i = 1'b0, tc_i = 1'b0, sxm_i = 1'b0;
    logic        c_i = 1'b0, hm_i = 1'b0, fsm_i = 1'b0, xf_i = 1'b0, fo_i = 1'b0;
    logic        txm_i = 1'b0, mem_we_o, busy_o;
    logic [15:0] mem_addr_o, mem_data_o, data2;
    logic [14:0] pats [4] = '{15'h7FFF, 15'h0000, 15'h5555, 15'h2AAA};
    int          bad_count = 0, total_checks = 0, cycles = 0, n0;

    always #5 sys_clk_i = ~sys_clk_i;

    sws_store_unit sws_store_unit_inst (.*);
    sws_store_unit #(.TWO_BIT_CNF(1'b1)) sws_store_unit_wide_inst (
        .*, .mem_we_o(), .mem_addr_o(), .mem_data_o(data2), .busy_o());
    sws_mem_model sws_mem_model_inst (.sys_clk_i(sys_clk_i), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .data_i(mem_data_o));

    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] img0();
        return {arp_i, ov_i, ovm_i, 1'b1, global_irq_mask_i, dp_i};
    endfunction

    function automatic logic [15:0] img1(input logic wide);
        return {arb_i, cnf_i[0], tc_i, sxm_i, c_i, 1'b1, wide ? cnf_i[1] : 1'b1,
                hm_i, fsm_i, xf_i, fo_i, txm_i, pm_i};
    endfunction

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic store(input logic op, input logic ind, input logic [6:0] ofs);
        logic [15:0] ea;
        ea = ind ? aux_reg_i : {9'h000, ofs};
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b1;
        instr_i       <= {7'b0111100, op, ind, ofs};
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b0;
        #1;
        chk("strobe", 16'h0001, {15'h0000, mem_we_o});
        chk("busy", 16'h0001, {15'h0000, busy_o});
        chk("addr", ea, mem_addr_o);
        chk("data", op ? img1(1'b0) : img0(), mem_data_o);
        if (op)
            chk("wide data", img1(1'b1), data2);
        @(posedge sys_clk_i);
        #1;
        chk("strobe end", 16'h0000, {15'h0000, mem_we_o});
        chk("memory", op ? img1(1'b0) : img0(), sws_mem_model_inst.mem[ea]);
    endtask

    // ****************
    // Tests
    // ****************
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        chk("reset out", 16'h0000, mem_addr_o | mem_data_o | {14'h0, mem_we_o, busy_o});
        $display("TEST reset done");
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            {arp_i, ov_i, ovm_i, global_irq_mask_i, dp_i} <= pats[i];
            {arb_i, cnf_i, tc_i, sxm_i, c_i, hm_i, fsm_i, xf_i, fo_i, txm_i, pm_i} <= ~pats[i];
            aux_reg_i <= {pats[i], 1'b1};
            store(1'b0, 1'b0, pats[i][6:0]);
            store(1'b0, 1'b1, pats[i][6:0]);
            store(1'b1, 1'b0, pats[i][6:0]);
            store(1'b1, 1'b1, pats[i][6:0]);
        end
        $display("TEST layouts done");
        n0 = sws_mem_model_inst.wr_count;
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b1;
        instr_i       <= 16'h7C05;
        @(posedge sys_clk_i);
        instr_i <= 16'h7805;
        @(posedge sys_clk_i);
        instr_i <= 16'h7806;
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk("write count", 16'h0001, 16'(sws_mem_model_inst.wr_count - n0));
        chk("last addr", 16'h0005, mem_addr_o);
        $display("TEST refusal done");
        summarize();
    end
endmodule // tb
